// ===== src/srx_pkg.sv
// Constants and types for the stack, rotate, subtract and exchange executor
package srx_pkg;

  // Opcodes
  localparam logic [7:0] OP_PUSH = 8'hC0;
  localparam logic [7:0] OP_SUB_RET = 8'h22;
  localparam logic [7:0] OP_INT_RET = 8'h32;
  localparam logic [7:0] OP_ROT_L = 8'h23;
  localparam logic [7:0] OP_ROT_LC = 8'h33;
  localparam logic [7:0] OP_ROT_R = 8'h03;
  localparam logic [7:0] OP_ROT_RC = 8'h13;
  localparam logic [7:0] OP_SET_CY = 8'hD3;
  localparam logic [7:0] OP_SET_BIT = 8'hD2;
  localparam logic [7:0] OP_BRANCH = 8'h80;
  localparam logic [7:0] OP_SUBTRACT_BORROW_OP_IMM = 8'h94;
  localparam logic [7:0] OP_SUBTRACT_BORROW_OP_DIR = 8'h95;
  localparam logic [7:0] OP_SUBTRACT_BORROW_OP_IND = 8'h96;
  localparam logic [7:0] OP_SUBTRACT_BORROW_OP_REG = 8'h98;
  localparam logic [7:0] OP_SWAP = 8'hC4;
  localparam logic [7:0] OP_XCH_DIR = 8'hC5;
  localparam logic [7:0] OP_XCH_IND = 8'hC6;
  localparam logic [7:0] OP_XCH_REG = 8'hC8;
  localparam logic [7:0] OP_DIGIT_EXCHANGE_OP_IND = 8'hD6;
  localparam logic [7:0] MASK_REG = 8'hF8;
  localparam logic [7:0] MASK_IND = 8'hFE;

  // Special function register addresses on the direct space
  localparam logic [7:0] SFR_ACC = 8'hE0;
  localparam logic [7:0] SFR_PSW = 8'hD0;
  localparam logic [7:0] SFR_SP = 8'h81;
  localparam logic [3:0] BIT_AREA_HI = 4'h2;

  // Status word fields
  localparam int PSW_CY = 7;
  localparam int PSW_AC = 6;
  localparam int PSW_RS_HI = 4;
  localparam int PSW_RS_LO = 3;
  localparam int PSW_OV = 2;

  // Reset values and step sizes
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] PSW_RST = 8'h00;
  localparam logic [7:0] SP_RST = 8'h07;
  localparam logic [7:0] SP_STEP = 8'h01;
  localparam logic [15:0] BRANCH_STEP = 16'h0002;

  // Wishbone register offsets (byte addresses)
  localparam logic [3:0] WB_CTRL = 4'h0;
  localparam logic [3:0] WB_STATUS = 4'h4;
  localparam logic [3:0] WB_COUNT = 4'h8;
  localparam int CTRL_RUN = 0;
  localparam logic CTRL_RST = 1'b0;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_PTR = 2'b01,
    S_EXEC = 2'b10,
    S_RET2 = 2'b11
  } srx_state_t;

endpackage

// ===== src/srx_ram.sv
// Internal data RAM, 256 bytes, one write and one registered read port
`timescale 1ns/1ns
module srx_ram (
  input wire logic clk_sys_i, // System clock
  input wire logic we_i, // Write strobe
  input wire logic [7:0] waddr_i, // Write address
  input wire logic [7:0] wdata_i, // Write data
  input wire logic [7:0] raddr_i, // Read address
  output logic [7:0] rdata_o // Read data, one cycle later
);

  logic [7:0] mem_r [0:255];

  always_ff @(posedge clk_sys_i) begin
    if (we_i) begin
      mem_r[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    rdata_o <= mem_r[raddr_i];
  end

endmodule

// ===== src/srx_exec.sv
// Executor for stack, return, rotate, set-bit, branch, subtract and exchange opcodes
//
// Register access over Wishbone and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
module srx_exec (
  input wire logic clk_sys_i, // 50 MHz system clock
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic instr_valid_i, // Fetch offers an instruction
  input wire logic [7:0] opcode_i, // First instruction byte
  input wire logic [7:0] arg_i, // Second instruction byte
  input wire logic [15:0] pc_i, // Address of the opcode
  output logic instr_ready_o, // Executor takes the offered instruction
  output logic instr_done_o, // Pulse: instruction finished
  output logic pc_load_o, // Pulse: program counter must load
  output logic [15:0] pc_value_o, // New program counter value
  output logic irq_rearm_o, // Pulse: release serviced priority level
  output logic irq_defer_o, // Level: hold pending interrupts
  output logic [7:0] acc_o, // Accumulator
  output logic [7:0] psw_o, // Program status word
  output logic [7:0] stack_pointer_o, // Stack pointer
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write enable
  input wire logic [3:0] wb_adr_i, // Wishbone byte address
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o // Wishbone acknowledge
);

  srx_pkg::srx_state_t state_r;
  srx_pkg::srx_state_t state_nxt;
  logic [7:0] op_r;
  logic [7:0] arg_r;
  logic [15:0] pc_base_r;
  logic [7:0] ea_r;
  logic [7:0] ea_idle;
  logic sfr_sel_r;
  logic [7:0] acc_r;
  logic [7:0] acc_nxt;
  logic [7:0] psw_r;
  logic [7:0] psw_nxt;
  logic [7:0] sp_r;
  logic [7:0] sp_nxt;
  logic [7:0] pc_hi_r;
  logic run_r;
  logic [31:0] count_r;
  logic take;
  logic finish;
  logic is_reg;
  logic is_ind;
  logic is_dir;
  logic is_pop;
  logic [7:0] ram_raddr;
  logic [7:0] ram_rdata;
  logic ram_we;
  logic [7:0] ram_waddr;
  logic [7:0] ram_wdata;
  logic [7:0] mem_val;
  logic [7:0] sfr_val;
  logic [7:0] src;
  logic [8:0] diff_full;
  logic [4:0] diff_low;
  logic [7:0] diff_seven;
  logic wr_en;
  logic [7:0] wr_val;
  logic [7:0] set_val;
  logic [15:0] branch_tgt;
  logic wb_hit;

  srx_ram u_ram (
    .clk_sys_i(clk_sys_i),
    .we_i(ram_we),
    .waddr_i(ram_waddr),
    .wdata_i(ram_wdata),
    .raddr_i(ram_raddr),
    .rdata_o(ram_rdata)
  );

  assign take = (state_r == srx_pkg::S_IDLE) && instr_valid_i && instr_ready_o;
  assign is_reg = ((opcode_i & srx_pkg::MASK_REG) == srx_pkg::OP_SUBTRACT_BORROW_OP_REG) ||
                  ((opcode_i & srx_pkg::MASK_REG) == srx_pkg::OP_XCH_REG);
  assign is_ind = ((opcode_i & srx_pkg::MASK_IND) == srx_pkg::OP_SUBTRACT_BORROW_OP_IND) ||
                  ((opcode_i & srx_pkg::MASK_IND) == srx_pkg::OP_XCH_IND) ||
                  ((opcode_i & srx_pkg::MASK_IND) == srx_pkg::OP_DIGIT_EXCHANGE_OP_IND);
  assign is_dir = (opcode_i == srx_pkg::OP_SUBTRACT_BORROW_OP_DIR) || (opcode_i == srx_pkg::OP_XCH_DIR) ||
                  (opcode_i == srx_pkg::OP_PUSH);
  assign is_pop = (op_r == srx_pkg::OP_SUB_RET) || (op_r == srx_pkg::OP_INT_RET);

  // Effective address chosen while the instruction is offered
  always_comb begin
    ea_idle = arg_i;
    if (is_reg) begin
      ea_idle = {3'b000, psw_r[srx_pkg::PSW_RS_HI:srx_pkg::PSW_RS_LO], opcode_i[2:0]};
    end else if (is_ind) begin
      ea_idle = {3'b000, psw_r[srx_pkg::PSW_RS_HI:srx_pkg::PSW_RS_LO], 2'b00, opcode_i[0]};
    end else if (opcode_i == srx_pkg::OP_SET_BIT) begin
      ea_idle = arg_i[7] ? {arg_i[7:3], 3'b000} : {srx_pkg::BIT_AREA_HI, arg_i[6:3]};
    end else if (opcode_i == srx_pkg::OP_SUB_RET || opcode_i == srx_pkg::OP_INT_RET) begin
      ea_idle = sp_r;
    end
  end

  // RAM read address per step
  always_comb begin
    case (state_r)
      srx_pkg::S_IDLE: ram_raddr = ea_idle;
      srx_pkg::S_PTR: ram_raddr = ram_rdata;
      srx_pkg::S_EXEC: ram_raddr = 8'(sp_r - srx_pkg::SP_STEP);
      default: ram_raddr = 8'h00;
    endcase
  end

  // Direct reads of the local special function registers
  always_comb begin
    case (ea_r)
      srx_pkg::SFR_ACC: sfr_val = acc_r;
      srx_pkg::SFR_PSW: sfr_val = psw_r;
      srx_pkg::SFR_SP: sfr_val = sp_r;
      default: sfr_val = 8'h00;
    endcase
  end

  assign mem_val = sfr_sel_r ? sfr_val : ram_rdata;
  assign src = (op_r == srx_pkg::OP_SUBTRACT_BORROW_OP_IMM) ? arg_r : mem_val;
  assign diff_full = 9'({1'b0, acc_r} - {1'b0, src} - {8'h00, psw_r[srx_pkg::PSW_CY]});
  assign diff_low = 5'({1'b0, acc_r[3:0]} - {1'b0, src[3:0]} -
                       {4'h0, psw_r[srx_pkg::PSW_CY]});
  assign diff_seven = 8'({1'b0, acc_r[6:0]} - {1'b0, src[6:0]} -
                         {7'h00, psw_r[srx_pkg::PSW_CY]});
  assign set_val = mem_val | (8'h01 << arg_r[2:0]);
  assign branch_tgt = 16'(pc_base_r + srx_pkg::BRANCH_STEP + {{8{arg_r[7]}}, arg_r});

  // Next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      srx_pkg::S_IDLE: begin
        if (take) begin
          state_nxt = is_ind ? srx_pkg::S_PTR : srx_pkg::S_EXEC;
        end
      end
      srx_pkg::S_PTR: state_nxt = srx_pkg::S_EXEC;
      srx_pkg::S_EXEC: state_nxt = is_pop ? srx_pkg::S_RET2 : srx_pkg::S_IDLE;
      srx_pkg::S_RET2: state_nxt = srx_pkg::S_IDLE;
      default: state_nxt = srx_pkg::S_IDLE;
    endcase
  end

  assign finish = (state_r == srx_pkg::S_RET2) || (state_r == srx_pkg::S_EXEC && !is_pop);

  // Datapath of the executing instruction
  always_comb begin
    acc_nxt = acc_r;
    psw_nxt = psw_r;
    sp_nxt = sp_r;
    ram_we = 1'b0;
    ram_waddr = ea_r;
    ram_wdata = 8'h00;
    wr_en = 1'b0;
    wr_val = 8'h00;
    if (state_r == srx_pkg::S_EXEC) begin
      if (op_r == srx_pkg::OP_PUSH) begin
        sp_nxt = 8'(sp_r + srx_pkg::SP_STEP);
        ram_we = 1'b1;
        ram_waddr = 8'(sp_r + srx_pkg::SP_STEP);
        ram_wdata = mem_val;
      end else if (is_pop) begin
        sp_nxt = 8'(sp_r - srx_pkg::SP_STEP);
      end else if (op_r == srx_pkg::OP_ROT_L) begin
        acc_nxt = {acc_r[6:0], acc_r[7]};
      end else if (op_r == srx_pkg::OP_ROT_LC) begin
        acc_nxt = {acc_r[6:0], psw_r[srx_pkg::PSW_CY]};
        psw_nxt[srx_pkg::PSW_CY] = acc_r[7];
      end else if (op_r == srx_pkg::OP_ROT_R) begin
        acc_nxt = {acc_r[0], acc_r[7:1]};
      end else if (op_r == srx_pkg::OP_ROT_RC) begin
        acc_nxt = {psw_r[srx_pkg::PSW_CY], acc_r[7:1]};
        psw_nxt[srx_pkg::PSW_CY] = acc_r[0];
      end else if (op_r == srx_pkg::OP_SET_CY) begin
        psw_nxt[srx_pkg::PSW_CY] = 1'b1;
      end else if (op_r == srx_pkg::OP_SET_BIT) begin
        wr_en = 1'b1;
        wr_val = set_val;
      end else if (op_r == srx_pkg::OP_SWAP) begin
        acc_nxt = {acc_r[3:0], acc_r[7:4]};
      end else if (op_r == srx_pkg::OP_SUBTRACT_BORROW_OP_IMM || op_r == srx_pkg::OP_SUBTRACT_BORROW_OP_DIR ||
                   (op_r & srx_pkg::MASK_IND) == srx_pkg::OP_SUBTRACT_BORROW_OP_IND ||
                   (op_r & srx_pkg::MASK_REG) == srx_pkg::OP_SUBTRACT_BORROW_OP_REG) begin
        acc_nxt = diff_full[7:0];
        psw_nxt[srx_pkg::PSW_CY] = diff_full[8];
        psw_nxt[srx_pkg::PSW_AC] = diff_low[4];
        psw_nxt[srx_pkg::PSW_OV] = diff_full[8] ^ diff_seven[7];
      end else if (op_r == srx_pkg::OP_XCH_DIR ||
                   (op_r & srx_pkg::MASK_IND) == srx_pkg::OP_XCH_IND ||
                   (op_r & srx_pkg::MASK_REG) == srx_pkg::OP_XCH_REG) begin
        acc_nxt = mem_val;
        wr_en = 1'b1;
        wr_val = acc_r;
      end else if ((op_r & srx_pkg::MASK_IND) == srx_pkg::OP_DIGIT_EXCHANGE_OP_IND) begin
        acc_nxt = {acc_r[7:4], mem_val[3:0]};
        wr_en = 1'b1;
        wr_val = {mem_val[7:4], acc_r[3:0]};
      end
      // Write back to RAM or to a local special function register
      if (wr_en) begin
        if (!sfr_sel_r) begin
          ram_we = 1'b1;
          ram_wdata = wr_val;
        end else if (ea_r == srx_pkg::SFR_ACC) begin
          acc_nxt = wr_val;
        end else if (ea_r == srx_pkg::SFR_PSW) begin
          psw_nxt = wr_val;
        end else if (ea_r == srx_pkg::SFR_SP) begin
          sp_nxt = wr_val;
        end
      end
    end else if (state_r == srx_pkg::S_RET2) begin
      sp_nxt = 8'(sp_r - srx_pkg::SP_STEP);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_r <= srx_pkg::S_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Instruction capture
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      op_r <= 8'h00;
      arg_r <= 8'h00;
      pc_base_r <= 16'h0000;
      ea_r <= 8'h00;
      sfr_sel_r <= 1'b0;
    end else if (take) begin
      op_r <= opcode_i;
      arg_r <= arg_i;
      pc_base_r <= pc_i;
      ea_r <= ea_idle;
      sfr_sel_r <= (is_dir || opcode_i == srx_pkg::OP_SET_BIT) && ea_idle[7];
    end else if (state_r == srx_pkg::S_PTR) begin
      ea_r <= ram_rdata;
      sfr_sel_r <= 1'b0;
    end
  end

  // Core registers; interrupt return touches only PC and stack pointer
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      acc_r <= srx_pkg::ACC_RST;
      psw_r <= srx_pkg::PSW_RST;
      sp_r <= srx_pkg::SP_RST;
    end else begin
      acc_r <= acc_nxt;
      psw_r <= psw_nxt;
      sp_r <= sp_nxt;
    end
  end

  // Program counter hand-back
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pc_hi_r <= 8'h00;
      pc_load_o <= 1'b0;
      pc_value_o <= 16'h0000;
    end else begin
      pc_load_o <= 1'b0;
      if (state_r == srx_pkg::S_EXEC && is_pop) begin
        pc_hi_r <= ram_rdata;
      end
      if (state_r == srx_pkg::S_RET2) begin
        pc_load_o <= 1'b1;
        pc_value_o <= {pc_hi_r, ram_rdata};
      end else if (state_r == srx_pkg::S_EXEC && op_r == srx_pkg::OP_BRANCH) begin
        pc_load_o <= 1'b1;
        pc_value_o <= branch_tgt;
      end
    end
  end

  // Interrupt controller hand-shake
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      irq_rearm_o <= 1'b0;
      irq_defer_o <= 1'b0;
    end else begin
      irq_rearm_o <= finish && op_r == srx_pkg::OP_INT_RET;
      if (finish) begin
        irq_defer_o <= op_r == srx_pkg::OP_INT_RET;
      end
    end
  end

  // Handshake toward fetch
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      instr_ready_o <= 1'b0;
      instr_done_o <= 1'b0;
    end else begin
      instr_ready_o <= run_r && !take && state_nxt == srx_pkg::S_IDLE;
      instr_done_o <= finish;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      acc_o <= srx_pkg::ACC_RST;
      psw_o <= srx_pkg::PSW_RST;
      stack_pointer_o <= srx_pkg::SP_RST;
    end else begin
      acc_o <= acc_nxt;
      psw_o <= psw_nxt;
      stack_pointer_o <= sp_nxt;
    end
  end

  // Wishbone slave: control, status and retired-instruction count
  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_hit;
      wb_dat_o <= 32'h0000_0000;
      if (wb_hit && !wb_we_i) begin
        case (wb_adr_i)
          srx_pkg::WB_CTRL: wb_dat_o <= {31'h0000_0000, run_r};
          srx_pkg::WB_STATUS: wb_dat_o <= {6'h00, state_r, sp_r, psw_r, acc_r};
          srx_pkg::WB_COUNT: wb_dat_o <= count_r;
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      run_r <= srx_pkg::CTRL_RST;
    end else if (wb_hit && wb_we_i && wb_adr_i == srx_pkg::WB_CTRL && wb_sel_i[0]) begin
      run_r <= wb_dat_i[srx_pkg::CTRL_RUN];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      count_r <= 32'h0000_0000;
    end else if (finish) begin
      count_r <= 32'(count_r + 32'h0000_0001);
    end
  end

endmodule

// ===== bench/srx_exec_chk.sv
// Port-level checker for the stack, rotate, subtract and exchange executor
`timescale 1ns/1ns
module srx_exec_chk (
  input wire logic clk_sys_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic instr_valid_i, // Offer
  input wire logic [7:0] opcode_i, // Opcode
  input wire logic [7:0] arg_i, // Second byte
  input wire logic [15:0] pc_i, // Opcode address
  input wire logic instr_ready_o, // Ready
  input wire logic instr_done_o, // Finished
  input wire logic pc_load_o, // PC load
  input wire logic [15:0] pc_value_o, // New PC
  input wire logic irq_rearm_o, // Level release
  input wire logic irq_defer_o, // Hold pending
  input wire logic [7:0] acc_o, // Accumulator
  input wire logic [7:0] psw_o, // Status
  input wire logic [7:0] stack_pointer_o, // Stack pointer
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Bus strobe
  input wire logic wb_ack_o // Bus acknowledge
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  logic tk;
  assign tk = instr_valid_i && instr_ready_o;
  chk_push_sp_up: assert property (tk && opcode_i == srx_pkg::OP_PUSH |-> ##2
    instr_done_o && stack_pointer_o == $past(stack_pointer_o, 2) + 8'h01)
    else $error("push stack step wrong");
  chk_ret_pop_two: assert property (tk && (opcode_i == srx_pkg::OP_SUB_RET ||
    opcode_i == srx_pkg::OP_INT_RET) |-> ##3 instr_done_o && pc_load_o
    && stack_pointer_o == $past(stack_pointer_o, 3) - 8'h02) else $error("return pop wrong");
  chk_interrupt_return_op_keep_regs: assert property (tk && opcode_i == srx_pkg::OP_INT_RET |-> ##3
    irq_rearm_o && irq_defer_o && acc_o == $past(acc_o, 3) && psw_o == $past(psw_o, 3))
    else $error("interrupt return wrong");
  chk_defer_start: assert property ($rose(irq_defer_o) |-> irq_rearm_o)
    else $error("defer without return");
  chk_defer_hold: assert property (irq_defer_o && !instr_done_o |=> irq_defer_o || instr_done_o)
    else $error("defer dropped early");
  chk_rotl_wrap: assert property (tk && opcode_i == srx_pkg::OP_ROT_L |-> ##2
    acc_o == (($past(acc_o, 2) << 1) | ($past(acc_o, 2) >> 7)) && psw_o == $past(psw_o, 2))
    else $error("rotate left wrong");
  chk_swap_nibble: assert property (tk && opcode_i == srx_pkg::OP_SWAP |-> ##2
    acc_o == (($past(acc_o, 2) << 4) | ($past(acc_o, 2) >> 4)) && psw_o == $past(psw_o, 2))
    else $error("nibble swap wrong");
  chk_branch_target: assert property (tk && opcode_i == srx_pkg::OP_BRANCH |-> ##2
    pc_load_o && pc_value_o == $past(pc_i, 2) + 16'h0002 + 16'($signed($past(arg_i, 2))))
    else $error("branch target wrong");
  chk_ack_single: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack shape wrong");
  chk_done_bound: assert property (tk |=> !instr_ready_o ##[1:2] instr_done_o)
    else $error("done late");
  cov_interrupt_return_op: cover property (tk && opcode_i == srx_pkg::OP_INT_RET);
  cov_defer_end: cover property (irq_defer_o && instr_done_o && !irq_rearm_o);
  cov_back_branch: cover property (tk && opcode_i == srx_pkg::OP_BRANCH && arg_i[7]);
endmodule
bind srx_exec srx_exec_chk u_chk (.clk_sys_i, .rst_i, .instr_valid_i, .opcode_i, .arg_i,
  .pc_i, .instr_ready_o, .instr_done_o, .pc_load_o, .pc_value_o, .irq_rearm_o, .irq_defer_o,
  .acc_o, .psw_o, .stack_pointer_o, .wb_cyc_i, .wb_stb_i, .wb_ack_o);

// ===== bench/tb_top.sv
// Random and corner-case bench for the executor and its register port
`timescale 1ns/1ns
module tb_top;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic instr_valid_i = 1'b0;
  logic [7:0] opcode_i = 8'h00;
  logic [7:0] arg_i = 8'h00;
  logic [15:0] pc_i = 16'h0000;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic instr_ready_o, instr_done_o, pc_load_o, irq_rearm_o, irq_defer_o, wb_ack_o;
  logic [15:0] pc_value_o, m_pc;
  logic [7:0] acc_o, psw_o, stack_pointer_o, m_acc, m_psw, m_sp;
  logic [7:0] m_ram [256];
  logic [31:0] wb_dat_o, rd;
  logic m_ld;
  int bad_count, n_compared, cycles, n_done;
  localparam logic [7:0] OPS [19] = '{srx_pkg::OP_PUSH, srx_pkg::OP_SUB_RET,
    srx_pkg::OP_INT_RET, srx_pkg::OP_ROT_L, srx_pkg::OP_ROT_LC, srx_pkg::OP_ROT_R,
    srx_pkg::OP_ROT_RC, srx_pkg::OP_SET_CY, srx_pkg::OP_SET_BIT, srx_pkg::OP_BRANCH,
    srx_pkg::OP_SUBTRACT_BORROW_OP_IMM, srx_pkg::OP_SUBTRACT_BORROW_OP_DIR, srx_pkg::OP_SUBTRACT_BORROW_OP_IND, srx_pkg::OP_SUBTRACT_BORROW_OP_REG,
    srx_pkg::OP_SWAP, srx_pkg::OP_XCH_DIR, srx_pkg::OP_XCH_IND, srx_pkg::OP_XCH_REG,
    srx_pkg::OP_DIGIT_EXCHANGE_OP_IND};
  localparam logic [7:0] RELS [4] = '{8'h80, 8'h7F, 8'hFE, 8'h00};
  srx_exec dut (.clk_sys_i, .rst_i, .instr_valid_i, .opcode_i, .arg_i, .pc_i, .instr_ready_o,
    .instr_done_o, .pc_load_o, .pc_value_o, .irq_rearm_o, .irq_defer_o, .acc_o, .psw_o,
    .stack_pointer_o, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o);
  always #10 clk_sys_i = ~clk_sys_i;
  task automatic complete_run();
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      complete_run();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] rd_dir(input logic [7:0] a);
    if (a < 8'h80) return m_ram[a];
    if (a == srx_pkg::SFR_ACC) return m_acc;
    if (a == srx_pkg::SFR_PSW) return m_psw;
    if (a == srx_pkg::SFR_SP) return m_sp;
    return 8'h00;
  endfunction
  function automatic void wr_dir(input logic [7:0] a, input logic [7:0] v);
    if (a < 8'h80) m_ram[a] = v;
    else if (a == srx_pkg::SFR_ACC) m_acc = v;
    else if (a == srx_pkg::SFR_PSW) m_psw = v;
    else if (a == srx_pkg::SFR_SP) m_sp = v;
  endfunction
  function automatic void subtract_borrow_op(input logic [7:0] s);
    logic [8:0] r;
    logic c;
    c = m_psw[7];
    r = {1'b0, m_acc} - {1'b0, s} - {8'h00, c};
    m_psw[6] = 5'(m_acc[3:0]) < 5'(s[3:0]) + 5'(c);
    m_psw[2] = r[8] ^ (8'(m_acc[6:0]) < 8'(s[6:0]) + 8'(c));
    m_psw[7] = r[8];
    m_acc = r[7:0];
  endfunction
  function automatic void accumulator_exchange_op(input logic [7:0] a, input logic dig);
    logic [7:0] t;
    t = m_ram[a];
    m_ram[a] = dig ? {t[7:4], m_acc[3:0]} : m_acc;
    m_acc = dig ? {m_acc[7:4], t[3:0]} : t;
  endfunction
  function automatic void model(input logic [7:0] op, input logic [7:0] ag,
                                input logic [15:0] pc);
    logic [7:0] t, rg, ad, b;
    rg = {3'b000, m_psw[4:3], op[2:0]};
    ad = m_ram[{3'b000, m_psw[4:3], 2'b00, op[0]}];
    b = ag[7] ? {ag[7:3], 3'b000} : 8'h20 + 8'(ag[6:3]);
    m_ld = 1'b0;
    case (op)
      srx_pkg::OP_PUSH: begin
        t = rd_dir(ag);
        m_sp = m_sp + 8'h01;
        m_ram[m_sp] = t;
      end
      srx_pkg::OP_SUB_RET, srx_pkg::OP_INT_RET: begin
        m_pc = {m_ram[m_sp], m_ram[m_sp - 8'h01]};
        m_sp = m_sp - 8'h02;
        m_ld = 1'b1;
      end
      srx_pkg::OP_ROT_L: m_acc = {m_acc[6:0], m_acc[7]};
      srx_pkg::OP_ROT_LC: {m_psw[7], m_acc} = {m_acc, m_psw[7]};
      srx_pkg::OP_ROT_R: m_acc = {m_acc[0], m_acc[7:1]};
      srx_pkg::OP_ROT_RC: {m_acc, m_psw[7]} = {m_psw[7], m_acc};
      srx_pkg::OP_SET_CY: m_psw[7] = 1'b1;
      srx_pkg::OP_SET_BIT: begin
        t = rd_dir(b);
        t[ag[2:0]] = 1'b1;
        wr_dir(b, t);
      end
      srx_pkg::OP_BRANCH: begin
        m_pc = pc + 16'h0002 + {{8{ag[7]}}, ag};
        m_ld = 1'b1;
      end
      srx_pkg::OP_SUBTRACT_BORROW_OP_IMM: subtract_borrow_op(ag);
      srx_pkg::OP_SUBTRACT_BORROW_OP_DIR: subtract_borrow_op(rd_dir(ag));
      srx_pkg::OP_SWAP: m_acc = {m_acc[3:0], m_acc[7:4]};
      srx_pkg::OP_XCH_DIR: begin
        t = rd_dir(ag);
        wr_dir(ag, m_acc);
        m_acc = t;
      end
      default: begin
        if ((op & srx_pkg::MASK_REG) == srx_pkg::OP_SUBTRACT_BORROW_OP_REG) subtract_borrow_op(m_ram[rg]);
        if ((op & srx_pkg::MASK_IND) == srx_pkg::OP_SUBTRACT_BORROW_OP_IND) subtract_borrow_op(m_ram[ad]);
        if ((op & srx_pkg::MASK_REG) == srx_pkg::OP_XCH_REG) accumulator_exchange_op(rg, 1'b0);
        if ((op & srx_pkg::MASK_IND) == srx_pkg::OP_XCH_IND) accumulator_exchange_op(ad, 1'b0);
        if ((op & srx_pkg::MASK_IND) == srx_pkg::OP_DIGIT_EXCHANGE_OP_IND) accumulator_exchange_op(ad, 1'b1);
      end
    endcase
  endfunction
  task automatic run_op(input logic [7:0] op, input logic [7:0] ag);
    logic [15:0] pc;
    pc = 16'($urandom);
    model(op, ag, pc);
    n_done++;
    @(posedge clk_sys_i);
    instr_valid_i <= 1'b1;
    opcode_i <= op;
    arg_i <= ag;
    pc_i <= pc;
    do @(negedge clk_sys_i); while (instr_ready_o !== 1'b1);
    @(posedge clk_sys_i);
    instr_valid_i <= 1'b0;
    do @(negedge clk_sys_i); while (instr_done_o !== 1'b1);
    check(acc_o, m_acc);
    check(psw_o, m_psw);
    check(stack_pointer_o, m_sp);
    check({pc_load_o, irq_rearm_o}, {m_ld, op == srx_pkg::OP_INT_RET});
    if (m_ld) check(pc_value_o, m_pc);
    @(negedge clk_sys_i);
    check(irq_defer_o, op == srx_pkg::OP_INT_RET);
  endtask
  task automatic rnd_op(input logic [7:0] op);
    logic [7:0] ag;
    ag = 8'($urandom);
    if (op != srx_pkg::OP_SET_BIT && op != srx_pkg::OP_BRANCH) ag[7] = 1'b0;
    if (op == srx_pkg::OP_SUBTRACT_BORROW_OP_REG || op == srx_pkg::OP_XCH_REG) op[2:0] = 3'($urandom);
    if (op == srx_pkg::OP_SUBTRACT_BORROW_OP_IND || op == srx_pkg::OP_XCH_IND || op == srx_pkg::OP_DIGIT_EXCHANGE_OP_IND)
      op[0] = 1'($urandom);
    run_op(op, ag);
  endtask
  task automatic load_acc(input logic [7:0] v);
    run_op(srx_pkg::OP_SUBTRACT_BORROW_OP_IMM, m_acc - {7'h00, m_psw[7]} - v);
  endtask
  task automatic wb_io(input logic we, input logic [3:0] adr, input logic [3:0] sel,
                       input logic [31:0] wd);
    @(posedge clk_sys_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= wd;
    do @(posedge clk_sys_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  initial begin
    void'($urandom(83));
    m_acc = srx_pkg::ACC_RST;
    m_psw = srx_pkg::PSW_RST;
    m_sp = srx_pkg::SP_RST;
    repeat (5) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    wb_io(1'b1, srx_pkg::WB_STATUS, 4'hF, 32'hFFFF_FFFF);
    wb_io(1'b0, srx_pkg::WB_STATUS, 4'hF, 32'h0);
    check(rd, {8'h00, m_sp, m_psw, m_acc});
    wb_io(1'b0, 4'hC, 4'hF, 32'h0);
    check(rd, 32'h0);
    wb_io(1'b1, srx_pkg::WB_CTRL, 4'hE, 32'h1);
    repeat (3) @(negedge clk_sys_i);
    check(instr_ready_o, 1'b0);
    wb_io(1'b1, srx_pkg::WB_CTRL, 4'hF, 32'h1);
    $display("test reset and registers done");
    // Stack pointer to top, then fill all RAM with known bytes
    load_acc(8'hFF);
    run_op(srx_pkg::OP_XCH_DIR, srx_pkg::SFR_SP);
    for (int i = 0; i < 256; i++) begin
      run_op(srx_pkg::OP_SUBTRACT_BORROW_OP_IMM, 8'($urandom));
      run_op(srx_pkg::OP_PUSH, srx_pkg::SFR_ACC);
    end
    $display("test stack fill done");
    load_acc(8'h18);
    run_op(srx_pkg::OP_XCH_DIR, srx_pkg::SFR_PSW);
    foreach (OPS[k]) rnd_op(OPS[k]);
    foreach (RELS[k]) run_op(srx_pkg::OP_BRANCH, RELS[k]);
    run_op(srx_pkg::OP_INT_RET, 8'h00);
    run_op(srx_pkg::OP_SWAP, 8'h00);
    load_acc(8'hFF);
    run_op(srx_pkg::OP_XCH_DIR, srx_pkg::SFR_SP);
    run_op(srx_pkg::OP_PUSH, 8'h05);
    run_op(srx_pkg::OP_SUB_RET, 8'h00);
    $display("test corners done");
    repeat (300) rnd_op(OPS[$urandom % 19]);
    $display("test random done");
    wb_io(1'b0, srx_pkg::WB_COUNT, 4'hF, 32'h0);
    check(rd, n_done);
    wb_io(1'b0, srx_pkg::WB_STATUS, 4'hF, 32'h0);
    check(rd, {8'h00, m_sp, m_psw, m_acc});
    wb_io(1'b1, srx_pkg::WB_CTRL, 4'hF, 32'h0);
    repeat (2) @(negedge clk_sys_i);
    check(instr_ready_o, 1'b0);
    $display("test final registers done");
    complete_run();
  end
endmodule
